// >>> design/tbc_timer.sv
module tbc_timer (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control bits
  input wire logic timer_run_in,
  input wire logic clk_source_sel_in,
  input wire logic ext_sync_bypass_in,
  input wire logic lp_osc_en_in,
  input wire logic [1:0] prescale_sel_in,
  input wire logic wide_access_en_in,
  input wire logic overflow_irq_en_in,
  input wire logic overflow_flag_clr_in,
  input wire logic sleep_in,
  // compare unit
  input wire logic [3:0] cmp_mode_sel_in,
  input wire logic [15:0] compare_value_in,
  input wire logic adc_enable_in,
  // pins
  input wire logic ext_clk_pin_in,
  input wire logic osc_clk_in,
  input wire logic [1:0] pin_level_in,
  input wire logic [1:0] port_c_direction_in,
  // byte register access
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic reg_sel_in,
  input wire logic [7:0] reg_wdata_in,
  // outputs
  output logic [7:0] reg_rdata_out,
  output logic [tbc_pkg::COUNT_W-1:0] counter_pair_out,
  output logic overflow_flag_out,
  output logic irq_out,
  output logic adc_start_out,
  output logic osc_running_out,
  output logic [1:0] pin_oe_n_out,
  output logic [1:0] pin_rd_out
);
  import tbc_pkg::*;

  logic [1:0] instr_div_r;
  logic instr_tick;
  logic sync1_r, sync2_r, sync_prev_r, async_prev_r;
  logic src_level, sync_edge, async_edge, src_tick;
  logic [2:0] presc_r;
  logic presc_hit, inc;
  logic [15:0] count_r, count_nxt;
  logic [7:0] high_buf_r;
  logic wr_low, wr_high, rd_low, trig, wrap;
  logic flag_r;
  tbc_mode_t mode;

  // terminal value of the prescaler for a select code
  function automatic logic [2:0] presc_mask(input logic [1:0] sel);
    case (sel)
      PRESC_DIV8: presc_mask = 3'h7;
      PRESC_DIV4: presc_mask = 3'h3;
      PRESC_DIV2: presc_mask = 3'h1;
      default: presc_mask = 3'h0;
    endcase
  endfunction : presc_mask

  // mode decode; sync select ignored for internal source
  always_comb begin
    if (clk_source_sel_in == SRC_INTERNAL) begin
      mode = TBC_MODE_TIMER;
    end else if (ext_sync_bypass_in) begin
      mode = TBC_MODE_ASYNC;
    end else begin
      mode = TBC_MODE_SYNC;
    end
  end

  // instruction cycle enable, core clock stalls in sleep
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      instr_div_r <= 2'h0;
    end else if (instr_div_r == INSTR_DIV_LAST) begin
      instr_div_r <= 2'h0;
    end else begin
      instr_div_r <= instr_div_r + 2'h1;
    end
  end
  assign instr_tick = (instr_div_r == INSTR_DIV_LAST) && !sleep_in;

  // oscillator output replaces the pin when enabled
  assign src_level = lp_osc_en_in ? osc_clk_in : ext_clk_pin_in;

  // two-flop synchroniser plus single-stage async capture
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync_prev_r <= 1'b0;
      async_prev_r <= 1'b0;
    end else begin
      sync1_r <= src_level;
      sync2_r <= sync1_r;
      sync_prev_r <= sync2_r;
      async_prev_r <= src_level;
    end
  end
  // the async path skips the synchroniser: lower latency, metastable risk
  assign sync_edge = sync2_r && !sync_prev_r && !sleep_in;
  assign async_edge = src_level && !async_prev_r;

  // pick the tick of the active mode
  always_comb begin
    case (mode)
      TBC_MODE_TIMER: src_tick = instr_tick;
      TBC_MODE_SYNC: src_tick = sync_edge;
      TBC_MODE_ASYNC: src_tick = async_edge;
      default: src_tick = 1'b0;
    endcase
  end

  // access decode
  assign wr_low = reg_wr_in && (reg_sel_in == SEL_LOW);
  assign wr_high = reg_wr_in && (reg_sel_in == SEL_HIGH);
  assign rd_low = reg_rd_in && (reg_sel_in == SEL_LOW);

  // prescaler, cleared only by low byte writes
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      presc_r <= PRESC_RST;
    end else if (wr_low) begin
      presc_r <= PRESC_RST;
    end else if (timer_run_in && src_tick) begin
      presc_r <= presc_hit ? PRESC_RST : presc_r + 3'h1;
    end
  end
  assign presc_hit = (presc_r & presc_mask(prescale_sel_in)) ==
                     presc_mask(prescale_sel_in);
  assign inc = timer_run_in && src_tick && presc_hit;

  // trigger: compare match in special mode; async mode not honoured
  assign trig = (cmp_mode_sel_in == CMP_MODE_SPECIAL) &&
                (count_r == compare_value_in) &&
                (mode != TBC_MODE_ASYNC);
  assign wrap = inc && !trig && (count_r == COUNT_MAX);

  // counter next value: write, then trigger, then increment
  always_comb begin
    count_nxt = count_r;
    if (wr_low) begin
      if (wide_access_en_in) begin
        count_nxt = {high_buf_r, reg_wdata_in};
      end else begin
        count_nxt = {count_r[15:8], reg_wdata_in};
      end
    end else if (wr_high && !wide_access_en_in) begin
      count_nxt = {reg_wdata_in, count_r[7:0]};
    end else if (trig) begin
      count_nxt = COUNT_MIN;
    end else if (inc) begin
      count_nxt = count_r + 16'h0001;
    end
  end

  // counter pair
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_r <= COUNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  // high byte buffer for wide access
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      high_buf_r <= BYTE_RST;
    end else if (wide_access_en_in && wr_high) begin
      high_buf_r <= reg_wdata_in;
    end else if (wide_access_en_in && rd_low) begin
      high_buf_r <= count_r[15:8];
    end
  end

  // read data; in wide mode the high address shows the buffer
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= BYTE_RST;
    end else if (reg_rd_in) begin
      if (reg_sel_in == SEL_LOW) begin
        reg_rdata_out <= count_r[7:0];
      end else if (wide_access_en_in) begin
        reg_rdata_out <= high_buf_r;
      end else begin
        reg_rdata_out <= count_r[15:8];
      end
    end
  end

  // overflow flag, a wrap in the clear cycle wins
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_r <= 1'b0;
    end else if (wrap) begin
      flag_r <= 1'b1;
    end else if (overflow_flag_clr_in) begin
      flag_r <= 1'b0;
    end
  end

  // registered outputs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
      adc_start_out <= 1'b0;
      osc_running_out <= 1'b0;
      pin_oe_n_out <= 2'b11;
      pin_rd_out <= 2'b00;
    end else begin
      irq_out <= flag_r && overflow_irq_en_in;
      adc_start_out <= trig && !wr_low && adc_enable_in;
      // sleep does not gate the oscillator
      osc_running_out <= lp_osc_en_in;
      if (lp_osc_en_in) begin
        pin_oe_n_out <= 2'b11;
        pin_rd_out <= 2'b00;
      end else begin
        pin_oe_n_out <= port_c_direction_in;
        pin_rd_out <= pin_level_in;
      end
    end
  end
  assign counter_pair_out = count_r;
  assign overflow_flag_out = flag_r;

  // checks
  property p_wrap_flag;
    @(posedge clk_in) disable iff (rst_in)
      wrap |=> overflow_flag_out;
  endproperty
  a_wrap_flag: assert property (p_wrap_flag)
    else $error("wrap did not set overflow flag");

  property p_irq_gate;
    @(posedge clk_in) disable iff (rst_in)
      ##1 irq_out == ($past(flag_r) && $past(overflow_irq_en_in));
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq does not follow flag and enable");

  property p_trig_reset;
    @(posedge clk_in) disable iff (rst_in)
      (trig && !reg_wr_in) |=> counter_pair_out == COUNT_MIN;
  endproperty
  a_trig_reset: assert property (p_trig_reset)
    else $error("trigger did not clear counter");

  property p_trig_no_flag;
    @(posedge clk_in) disable iff (rst_in)
      (trig && !flag_r) |=> !overflow_flag_out;
  endproperty
  a_trig_no_flag: assert property (p_trig_no_flag)
    else $error("trigger set overflow flag");

  property p_write_wins;
    @(posedge clk_in) disable iff (rst_in)
      (trig && wr_low && !wide_access_en_in) |=>
        counter_pair_out[7:0] == $past(reg_wdata_in);
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("trigger overrode counter write");

  property p_presc_clear;
    @(posedge clk_in) disable iff (rst_in)
      wr_low |=> presc_r == PRESC_RST;
  endproperty
  a_presc_clear: assert property (p_presc_clear)
    else $error("low write did not clear prescaler");

  property p_wide_high_write;
    @(posedge clk_in) disable iff (rst_in)
      (wide_access_en_in && wr_high && !trig && !inc) |=>
        $stable(counter_pair_out) && high_buf_r == $past(reg_wdata_in);
  endproperty
  a_wide_high_write: assert property (p_wide_high_write)
    else $error("wide high write touched live counter");

  property p_osc_pins;
    @(posedge clk_in) disable iff (rst_in)
      lp_osc_en_in |=> pin_rd_out == 2'b00 && pin_oe_n_out == 2'b11;
  endproperty
  a_osc_pins: assert property (p_osc_pins)
    else $error("pins not forced to input while oscillator on");

  property p_stopped_holds;
    @(posedge clk_in) disable iff (rst_in)
      (!timer_run_in && !reg_wr_in && !trig) |=> $stable(counter_pair_out);
  endproperty
  a_stopped_holds: assert property (p_stopped_holds)
    else $error("stopped counter changed");

  property p_timer_rate;
    @(posedge clk_in) disable iff (rst_in)
      (mode == TBC_MODE_TIMER && timer_run_in && instr_tick &&
       prescale_sel_in == PRESC_DIV1 && !reg_wr_in && !trig &&
       count_r != COUNT_MAX) |=>
        counter_pair_out == $past(count_r) + 16'h0001;
  endproperty
  a_timer_rate: assert property (p_timer_rate)
    else $error("timer did not step on instruction cycle");

  c_wrap: cover property (@(posedge clk_in) disable iff (rst_in) wrap);
  c_trig: cover property (@(posedge clk_in) disable iff (rst_in)
    trig ##1 adc_start_out);
  c_wide_read: cover property (@(posedge clk_in) disable iff (rst_in)
    wide_access_en_in && rd_low);
  c_async: cover property (@(posedge clk_in) disable iff (rst_in)
    mode == TBC_MODE_ASYNC && inc);
endmodule : tbc_timer

// >>> design/tbc_pkg.sv
package tbc_pkg;
  // core clock and instruction cycle
  localparam int CLK_PERIOD_NS = 8;
  localparam int CLKS_PER_INSTR = 4;
  localparam logic [1:0] INSTR_DIV_LAST = 2'(CLKS_PER_INSTR - 1);

  // counter range
  localparam int COUNT_W = 16;
  localparam logic [15:0] COUNT_MIN = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // byte select on the register access port
  localparam logic SEL_LOW = 1'b0;
  localparam logic SEL_HIGH = 1'b1;

  // clock source select values
  localparam logic SRC_INTERNAL = 1'b0;
  localparam logic SRC_EXTERNAL = 1'b1;

  // compare unit mode code for the special event trigger
  localparam logic [3:0] CMP_MODE_SPECIAL = 4'hB;

  // prescale select codes
  localparam logic [1:0] PRESC_DIV1 = 2'h0;
  localparam logic [1:0] PRESC_DIV2 = 2'h1;
  localparam logic [1:0] PRESC_DIV4 = 2'h2;
  localparam logic [1:0] PRESC_DIV8 = 2'h3;
  localparam logic [2:0] PRESC_RST = 3'h0;

  // clock path selection
  typedef enum logic [1:0] {
    TBC_MODE_TIMER = 2'b00,
    TBC_MODE_SYNC = 2'b01,
    TBC_MODE_ASYNC = 2'b10
  } tbc_mode_t;
endpackage : tbc_pkg

// >>> bench/tbc_clk_src.sv
// partner: external clock pin or watch crystal, bursts only
module tbc_clk_src (
  // control from the bench
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic osc_sel_in,
  input wire logic [7:0] n_in,
  input wire logic [3:0] half_in,
  // clock lines
  output logic ext_clk_out,
  output logic osc_clk_out,
  output logic busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lvl;
  // line rests low between bursts; moves off the core edge
  initial begin
    lvl = 1'b0;
    busy_out = 1'b0;
    forever begin
      @(posedge clk_in);
      if (go_in === 1'b1) begin
        busy_out = 1'b1;
        repeat (2 * n_in) begin
          repeat (half_in) @(posedge clk_in);
          #3 lvl = ~lvl;
        end
        busy_out = 1'b0;
      end
    end
  end
  // only the selected source toggles
  assign ext_clk_out = lvl & ~osc_sel_in;
  assign osc_clk_out = lvl & osc_sel_in;
endmodule : tbc_clk_src

// >>> bench/tbc_timer_tb_top.sv
module tbc_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tbc_pkg::*;
  typedef struct {
    logic [15:0] c;
    logic [15:0] sl;
    logic [5:0] b;
    logic [5:0] m;
  } tbc_note_t;
  logic clk_in, rst_in, run, src, byp, osc, wide, ie, clr, slp, aen;
  logic wr, rd, sel, snap, rd_d, go, flag, irq, adc, oscr, ext, oscc, busy;
  logic [1:0] psel, lvl, dir, oe_n, prd;
  logic [3:0] mode, half;
  logic [7:0] wd, rdata, n_edge;
  logic [15:0] cmpv, cnt, v;
  tbc_note_t q_cnt[$];
  logic [7:0] q_byte[$];
  int n_errors, checked, n_adc, adc_base;
  integer seed;

  tbc_timer uut (.clk_in(clk_in), .rst_in(rst_in), .timer_run_in(run),
    .clk_source_sel_in(src), .ext_sync_bypass_in(byp), .lp_osc_en_in(osc),
    .prescale_sel_in(psel), .wide_access_en_in(wide),
    .overflow_irq_en_in(ie), .overflow_flag_clr_in(clr), .sleep_in(slp),
    .cmp_mode_sel_in(mode), .compare_value_in(cmpv), .adc_enable_in(aen),
    .ext_clk_pin_in(ext), .osc_clk_in(oscc), .pin_level_in(lvl),
    .port_c_direction_in(dir), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_sel_in(sel), .reg_wdata_in(wd), .reg_rdata_out(rdata),
    .counter_pair_out(cnt), .overflow_flag_out(flag), .irq_out(irq),
    .adc_start_out(adc), .osc_running_out(oscr), .pin_oe_n_out(oe_n),
    .pin_rd_out(prd));
  tbc_clk_src part (.clk_in(clk_in), .go_in(go), .osc_sel_in(osc),
    .n_in(n_edge), .half_in(half), .ext_clk_out(ext),
    .osc_clk_out(oscc), .busy_out(busy));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc
  task automatic fail(input string s);
    $display("unexpected at %0t: %s", $time, s);
    n_errors++;
  endtask : fail
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic wr8(input logic s, input logic [7:0] d);
    @(posedge clk_in);
    wr <= 1'b1;
    sel <= s;
    wd <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr8
  task automatic wr16(input logic [15:0] x);
    wr8(SEL_HIGH, x[15:8]);
    wr8(SEL_LOW, x[7:0]);
  endtask : wr16
  task automatic rd8(input logic s, input logic [7:0] e);
    @(posedge clk_in);
    rd <= 1'b1;
    sel <= s;
    q_byte.push_back(e);
    @(posedge clk_in);
    rd <= 1'b0;
  endtask : rd8
  // bits are {flag, irq, oe_n, pin_rd}; m masks the ones that matter
  task automatic note(input logic [15:0] c, sl, input logic [5:0] b, m);
    @(posedge clk_in);
    snap <= 1'b1;
    q_cnt.push_back(tbc_note_t'{c, sl, b, m});
    @(posedge clk_in);
    snap <= 1'b0;
  endtask : note
  // on_busy high waits on the partner's busy line, low on the flag
  task automatic wait_on(input logic on_busy, input logic x);
    for (int i = 0; i < 3000 && (on_busy ? busy : flag) !== x; i++) cyc(1);
    if ((on_busy ? busy : flag) !== x) begin
      fail("wait bound ran out");
      conclude();
    end
  endtask : wait_on
  task automatic burst(input logic [7:0] n);
    @(posedge clk_in);
    n_edge <= n;
    half <= 4'(2 + ($unsigned($random(seed)) % 4));
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    cyc(2);
    wait_on(1'b1, 1'b0);
  endtask : burst
  task automatic cmp_count(input tbc_note_t n);
    checked++;
    if ((16'(cnt - n.c) <= n.sl) !== 1'b1 ||
        ((({flag, irq, oe_n, prd} ^ n.b) & n.m) !== 6'h00))
      fail("counter or status");
  endtask : cmp_count
  task automatic cmp_byte(input logic [7:0] e);
    checked++;
    if (rdata !== e) fail("read data");
  endtask : cmp_byte
  task automatic cmp_pulses(input int lo, hi);
    checked++;
    if (n_adc - adc_base < lo || n_adc - adc_base > hi)
      fail("conversion start count");
  endtask : cmp_pulses
  task automatic cmp_osc(input logic e);
    checked++;
    if (oscr !== e) fail("oscillator running");
  endtask : cmp_osc

  // watcher: results land one edge after their strobe
  always @(posedge clk_in) begin
    if (rd_d === 1'b1) cmp_byte(q_byte.pop_front());
    if (snap === 1'b1) cmp_count(q_cnt.pop_front());
    if (adc === 1'b1) n_adc++;
    rd_d <= rd;
  end

  // hang guard, well over the length of the run
  initial begin
    cyc(90000);
    fail("run did not finish");
    conclude();
  end

  initial begin
    seed = 32'h91BB1A70;
    {run, src, byp, osc, wide, ie, clr, slp, aen} = '0;
    {wr, rd, sel, snap, go} = '0;
    {psel, lvl, mode, cmpv, wd, n_edge} = '0;
    dir = 2'h3;
    half = 4'h2;
    rst_in = 1'b1;
    cyc(8);
    rst_in <= 1'b0;
    note(COUNT_RST, 16'h0000, 6'h0C, 6'h3F);
    // buffered pair access
    wide <= 1'b1;
    wr16(16'h8000);
    note(16'h8000, 16'h0000, 6'h00, 6'h00);
    wr8(SEL_HIGH, 8'h55);
    note(16'h8000, 16'h0000, 6'h00, 6'h00);
    rd8(SEL_LOW, 8'h00);
    rd8(SEL_HIGH, 8'h80);
    // direct bytes with random data
    wide <= 1'b0;
    v = 16'($random(seed));
    wr16(v);
    note(v, 16'h0000, 6'h00, 6'h00);
    rd8(SEL_HIGH, v[15:8]);
    wide <= 1'b1;
    // run spans 5 * ratio instruction cycles, so exactly five steps
    for (int p = 0; p < 4; p++) begin
      psel <= 2'(p);
      wr16(16'h0000);
      run <= 1'b1;
      cyc(CLKS_PER_INSTR * 5 * (1 << p));
      run <= 1'b0;
      cyc(3);
      note(16'h0005, 16'h0000, 6'h00, 6'h00);
      cnt_hold: cyc(30);
      note(16'h0005, 16'h0000, 6'h00, 6'h00);
    end
    // wrap sets the flag; irq follows the enable
    psel <= PRESC_DIV1;
    ie <= 1'b1;
    wr16(16'hFFFE);
    run <= 1'b1;
    wait_on(1'b0, 1'b1);
    run <= 1'b0;
    cyc(3);
    note(COUNT_MIN, 16'h0002, 6'h30, 6'h30);
    ie <= 1'b0;
    cyc(2);
    note(COUNT_MIN, 16'h0002, 6'h20, 6'h30);
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    // period from the compare value; trigger driven here in timer mode only (the design also honours it in synchronised mode, not async)
    mode <= CMP_MODE_SPECIAL;
    cmpv <= 16'h0008;
    aen <= 1'b1;
    wr16(16'h0000);
    adc_base = n_adc;
    run <= 1'b1;
    cyc(320);
    run <= 1'b0;
    cyc(3);
    note(16'h0000, 16'h0008, 6'h00, 6'h20);
    cmp_pulses(9, 11);
    aen <= 1'b0;
    adc_base = n_adc;
    run <= 1'b1;
    cyc(100);
    run <= 1'b0;
    cmp_pulses(0, 0);
    // low write lands while a zero compare holds the count at zero
    wide <= 1'b0;
    cmpv <= 16'h0000;
    wr16(16'h0000);
    wr8(SEL_LOW, 8'h5A);
    note(16'h005A, 16'h0000, 6'h00, 6'h00);
    mode <= 4'h0;
    // synchronised external pin
    src <= SRC_EXTERNAL;
    wr16(16'h0000);
    run <= 1'b1;
    burst(8'h06);
    cyc(6);
    run <= 1'b0;
    cyc(3);
    note(16'h0006, 16'h0000, 6'h00, 6'h00);
    // crystal, asynchronous, core asleep; start-up wait first
    dir <= 2'($random(seed));
    lvl <= 2'($random(seed));
    osc <= 1'b1;
    cyc(20);
    cmp_osc(1'b1);
    byp <= 1'b1;
    wr16(16'h0000);
    run <= 1'b1;
    slp <= 1'b1;
    burst(8'h05);
    cyc(6);
    cmp_osc(1'b1);
    run <= 1'b0;
    slp <= 1'b0;
    cyc(3);
    note(16'h0005, 16'h0000, 6'h0C, 6'h0F);
    osc <= 1'b0;
    cyc(3);
    cmp_osc(1'b0);
    note(16'h0005, 16'h0000, {2'b00, dir, lvl}, 6'h0F);
    conclude();
  end
endmodule : tbc_timer_tb_top
